// *** hdl/ioc_pkg.sv ***
// constants, carrier types and helpers of the i/o port input-change block
package ioc_pkg;
  localparam int IOC_PORT_W = 8;
  localparam int IOC_ADDR_W = 8;
  // read offsets
  localparam logic [7:0] IOC_OFF_A_UPPER_CHANGE = 8'h13;
  localparam logic [7:0] IOC_OFF_A_LOWER_CHANGE = 8'h14;
  localparam logic [7:0] IOC_OFF_A_LEVEL = 8'h15;
  localparam logic [7:0] IOC_OFF_B_UPPER_CHANGE = 8'h1b;
  localparam logic [7:0] IOC_OFF_B_LOWER_CHANGE = 8'h1c;
  localparam logic [7:0] IOC_OFF_B_LEVEL = 8'h1d;
  // write offsets; configuration shares addresses with the change registers
  localparam logic [7:0] IOC_OFF_PORT_CONFIG_0 = 8'h13;
  localparam logic [7:0] IOC_OFF_PORT_CONFIG_1 = 8'h14;
  localparam logic [7:0] IOC_OFF_PORT_CONFIG_2 = 8'h1b;
  localparam logic [7:0] IOC_OFF_PORT_CONFIG_3 = 8'h1c;
  localparam logic [7:0] IOC_OFF_A_DETECT_ENABLE = 8'h32;
  localparam logic [7:0] IOC_OFF_B_DETECT_ENABLE = 8'h3a;
  // implemented pins and writable fields
  localparam logic [7:0] IOC_B_PIN_MASK = 8'h5d;
  localparam logic [7:0] IOC_CFG2_MASK = 8'hf3;
  localparam logic [7:0] IOC_CFG3_MASK = 8'h33;
  localparam logic [7:0] IOC_CFG_RESET = 8'h00;
  localparam logic [7:0] IOC_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IOC_UNMAPPED_READ = 8'h00;
  localparam logic [3:0] IOC_LOWER_NIBBLE = 4'hf;
  localparam int IOC_RTS_PIN = 0;

  typedef struct packed {
    logic [IOC_PORT_W-1:0] level;
    logic [IOC_PORT_W-1:0] enable;
  } ioc_drive_s;

  typedef struct packed {
    logic [IOC_PORT_W-1:0] prev;
    logic [IOC_PORT_W-1:0] flag;
  } ioc_det_state_s;

  typedef struct packed {
    logic [3:0][7:0] cfg;
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] rdata;
    ioc_drive_s drv_a;
    ioc_drive_s drv_b;
  } ioc_top_state_s;

  // a 2-bit field of 00 leaves the driver off, anything else turns it on
  function automatic logic [7:0] ioc_oe_of(input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] oe;
    oe = 8'h00;
    for (int i = 0; i < 4; i++) begin
      oe[i] = |lo[2*i +: 2];
      oe[i+4] = |hi[2*i +: 2];
    end
    return oe;
  endfunction

  // change flags in the high nibble, pin levels in the low nibble
  function automatic logic [7:0] ioc_nibble(input logic [3:0] flags, input logic [3:0] lvl);
    return {flags, lvl};
  endfunction
endpackage

// *** hdl/ioc_sync.sv ***
// two-flop synchroniser for the port pins
`timescale 1ns/1ps
`default_nettype none
module ioc_sync
  import ioc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic [W-1:0] async_in, // raw pin levels
  output logic [W-1:0] sync_out // levels in clk domain
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ioc_sync_state_s;

  ioc_sync_state_s state;
  ioc_sync_state_s next_state;

  always_comb begin
    next_state.s1 = async_in;
    next_state.s2 = state.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.s2;
endmodule // ioc_sync
`default_nettype wire

// *** hdl/ioc_detect.sv ***
// per-pin change-of-state detectors with sticky flags
`timescale 1ns/1ps
`default_nettype none
module ioc_detect
  import ioc_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic [IOC_PORT_W-1:0] lvl, // synchronised levels
  input wire logic [IOC_PORT_W-1:0] en, // detector enables
  input wire logic [IOC_PORT_W-1:0] clr, // clear on read
  output logic [IOC_PORT_W-1:0] change, // level differs from last sample
  output logic [IOC_PORT_W-1:0] flag // sticky change flags
);
  ioc_det_state_s state;
  ioc_det_state_s next_state;

  assign change = lvl ^ state.prev;

  always_comb begin
    next_state.prev = lvl;
    // set beats clear so an edge during the read is kept; disabled reads 0
    next_state.flag = ((state.flag & ~clr) | change) & en;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;
endmodule // ioc_detect
`default_nettype wire

// *** hdl/ioc_top.sv ***
// i/o port pair: level readback, change detection, configuration
// How it works
// - port b upper change register shows pin 6 and 4 change flags at bits 6, 4
// - bits 2 and 0 of that register show pin 6 and 4 live levels
// - port a level register reads all eight port a pin levels
// - port b level register reads pins 6, 4, 3, 2, 0; others zero
// - port a enable bit turns that pin's change detector on or off
// - detectors keep working while the pin is driven as an output
// - port b enable bits exist for pins 6, 4, 3, 2, 0 only
// - four configuration registers of 2-bit pin fields set direction: four fields each in 0 and 1, three in 2, two in 3
// - first mode bit 7 drives pin 0b as request-to-send, active low
// - second mode bit 5 makes pin 0b signal end of transmission while first mode bit 7 is clear
// - field 00 only turns off the driver; input path always works
// - self-driven pin levels still reach interrupts and counters
// - reset clears all configuration registers, every pin an input
// - an input serves clock, clear-to-send and general input at once
// - change results go to interrupt logic or are polled by software
// - a change flag reads zero while its detector is disabled
`timescale 1ns/1ps
`default_nettype none
module ioc_top
  import ioc_pkg::*;
(
  input wire logic SYS_CLK, // system clock, 100 MHz
  input wire logic RESET_N, // synchronous reset, low
  input wire logic [IOC_ADDR_W-1:0] BUS_ADDR, // register address
  input wire logic [7:0] BUS_WDATA, // write data
  input wire logic BUS_WR, // write strobe, one cycle
  input wire logic BUS_RD, // read strobe, one cycle
  output logic [7:0] BUS_RDATA, // read data, registered
  input wire logic [IOC_PORT_W-1:0] PORT_A_IN, // port a pin levels
  input wire logic [IOC_PORT_W-1:0] PORT_B_IN, // port b pin levels
  input wire logic [IOC_PORT_W-1:0] PORT_A_SRC, // port a output sources
  input wire logic [IOC_PORT_W-1:0] PORT_B_SRC, // port b output sources
  output ioc_drive_s PORT_A_DRV, // port a pin level and enable
  output ioc_drive_s PORT_B_DRV, // port b pin level and enable
  input wire logic RTS_FLOW_EN, // first mode register bit 7
  input wire logic REQUEST_TO_SEND_N, // flow-control level, low active
  input wire logic EOT_EN, // second mode register bit 5
  input wire logic EOT_LEVEL, // end-of-transmission level
  output logic [IOC_PORT_W-1:0] LEVEL_A, // synchronised port a levels
  output logic [IOC_PORT_W-1:0] LEVEL_B, // synchronised port b levels
  output logic CHANGE_PENDING // any change flag set
);
  ioc_top_state_s state;
  ioc_top_state_s next_state;
  logic [15:0] lvl_ab;
  logic [7:0] lvl_a;
  logic [7:0] lvl_b;
  logic [7:0] ch_a;
  logic [7:0] ch_b;
  logic [7:0] flag_a;
  logic [7:0] flag_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic [7:0] oe_a;
  logic [7:0] oe_b;
  logic [7:0] rd_mux;

  ioc_sync #(
    .W(2*IOC_PORT_W)
  ) u_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .async_in({PORT_B_IN, PORT_A_IN}),
    .sync_out(lvl_ab)
  );

  // unimplemented port b pins never reach the logic
  assign lvl_a = lvl_ab[7:0];
  assign lvl_b = lvl_ab[15:8] & IOC_B_PIN_MASK;

  // detectors look at pin levels whether driven or not
  ioc_detect u_det_a (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .lvl(lvl_a),
    .en(state.en_a),
    .clr(clr_a),
    .change(ch_a),
    .flag(flag_a)
  );

  ioc_detect u_det_b (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .lvl(lvl_b),
    .en(state.en_b),
    .clr(clr_b),
    .change(ch_b),
    .flag(flag_b)
  );

  // reading a change register clears the flags it shows
  always_comb begin
    clr_a = 8'h00;
    clr_b = 8'h00;
    if (BUS_RD) begin
      case (BUS_ADDR)
        IOC_OFF_A_LOWER_CHANGE: begin
          clr_a[3:0] = IOC_LOWER_NIBBLE;
        end
        IOC_OFF_A_UPPER_CHANGE: begin
          clr_a[7:4] = IOC_LOWER_NIBBLE;
        end
        IOC_OFF_B_LOWER_CHANGE: begin
          clr_b[3:0] = IOC_LOWER_NIBBLE;
        end
        IOC_OFF_B_UPPER_CHANGE: begin
          clr_b[7:4] = IOC_LOWER_NIBBLE;
        end
        default: begin
          clr_a = 8'h00;
        end
      endcase
    end
  end

  // upper b: flags 6,4 in bits 6,4; masked pins keep 7,5 at zero
  // upper b: levels of pins 6,4 in bits 2,0
  always_comb begin
    case (BUS_ADDR)
      IOC_OFF_A_UPPER_CHANGE: begin
        rd_mux = ioc_nibble(flag_a[7:4], lvl_a[7:4]);
      end
      IOC_OFF_A_LOWER_CHANGE: begin
        rd_mux = ioc_nibble(flag_a[3:0], lvl_a[3:0]);
      end
      IOC_OFF_A_LEVEL: begin
        rd_mux = lvl_a;
      end
      IOC_OFF_B_UPPER_CHANGE: begin
        rd_mux = ioc_nibble(flag_b[7:4], lvl_b[7:4]);
      end
      IOC_OFF_B_LOWER_CHANGE: begin
        rd_mux = ioc_nibble(flag_b[3:0], lvl_b[3:0]);
      end
      IOC_OFF_B_LEVEL: begin
        rd_mux = lvl_b;
      end
      IOC_OFF_A_DETECT_ENABLE: begin
        rd_mux = state.en_a;
      end
      IOC_OFF_B_DETECT_ENABLE: begin
        rd_mux = state.en_b;
      end
      default: begin
        rd_mux = IOC_UNMAPPED_READ;
      end
    endcase
  end

  // field 00 only switches the driver off
  assign oe_a = ioc_oe_of(state.cfg[0], state.cfg[1]);
  assign oe_b = ioc_oe_of(state.cfg[2], state.cfg[3]);

  always_comb begin
    next_state = state;
    if (BUS_RD) begin
      next_state.rdata = rd_mux;
    end
    if (BUS_WR) begin
      case (BUS_ADDR)
        // four configuration registers of 2-bit fields
        IOC_OFF_PORT_CONFIG_0: begin
          next_state.cfg[0] = BUS_WDATA;
        end
        IOC_OFF_PORT_CONFIG_1: begin
          next_state.cfg[1] = BUS_WDATA;
        end
        IOC_OFF_PORT_CONFIG_2: begin
          next_state.cfg[2] = BUS_WDATA & IOC_CFG2_MASK;
        end
        IOC_OFF_PORT_CONFIG_3: begin
          next_state.cfg[3] = BUS_WDATA & IOC_CFG3_MASK;
        end
        // one enable bit per port a pin
        IOC_OFF_A_DETECT_ENABLE: begin
          next_state.en_a = BUS_WDATA;
        end
        IOC_OFF_B_DETECT_ENABLE: begin
          next_state.en_b = BUS_WDATA & IOC_B_PIN_MASK;
        end
        default: begin
          next_state.en_a = state.en_a;
        end
      endcase
    end
    next_state.drv_a.level = PORT_A_SRC;
    next_state.drv_a.enable = oe_a;
    next_state.drv_b.level = PORT_B_SRC & IOC_B_PIN_MASK;
    next_state.drv_b.enable = oe_b;
    // flow control takes pin 0b over the configuration field
    if (RTS_FLOW_EN) begin
      next_state.drv_b.level[IOC_RTS_PIN] = REQUEST_TO_SEND_N;
      next_state.drv_b.enable[IOC_RTS_PIN] = 1'b1;
    // end of transmission when flow control is off
    end else if (EOT_EN) begin
      next_state.drv_b.level[IOC_RTS_PIN] = EOT_LEVEL;
      next_state.drv_b.enable[IOC_RTS_PIN] = 1'b1;
    end
  end

  // reset makes every pin an input
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state.cfg <= {4{IOC_CFG_RESET}};
      state.en_a <= IOC_ENABLE_RESET;
      state.en_b <= IOC_ENABLE_RESET;
      state.rdata <= IOC_UNMAPPED_READ;
      state.drv_a <= '0;
      state.drv_b <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign BUS_RDATA = state.rdata;
  assign PORT_A_DRV = state.drv_a;
  assign PORT_B_DRV = state.drv_b;
  // own driven levels return here for counters and clock inputs
  // one synchronised level feeds every input function at once
  assign LEVEL_A = lvl_a;
  assign LEVEL_B = lvl_b;
  // summary for the interrupt logic; polling uses the registers
  assign CHANGE_PENDING = |{flag_a, flag_b};

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_reset_inputs: assert property (
    $rose(RESET_N) |-> (PORT_A_DRV.enable == 8'h00) && (PORT_B_DRV.enable == 8'h00)
  ) else $error("pins driven right after reset");

  a_flag_needs_enable: assert property (
    ((flag_a & ~state.en_a) == 8'h00) && ((flag_b & ~state.en_b) == 8'h00)
  ) else $error("change flag set with detector disabled");

  a_change_sets_flag: assert property (
    (|(ch_a & state.en_a)) && !BUS_WR |=> ((flag_a & $past(ch_a & state.en_a))
      == $past(ch_a & state.en_a))
  ) else $error("enabled change did not set flag");

  a_read_clears_upper: assert property (
    BUS_RD && BUS_ADDR == IOC_OFF_A_UPPER_CHANGE && ch_a[7:4] == 4'h0
      |=> flag_a[7:4] == 4'h0
  ) else $error("upper port a flags not cleared by read");

  a_level_a_read: assert property (
    BUS_RD && BUS_ADDR == IOC_OFF_A_LEVEL |=> BUS_RDATA == $past(lvl_ab[7:0])
  ) else $error("port a level readback wrong");

  a_level_b_read: assert property (
    BUS_RD && BUS_ADDR == IOC_OFF_B_LEVEL
      |=> BUS_RDATA == ($past(lvl_ab[15:8]) & IOC_B_PIN_MASK)
  ) else $error("port b level readback wrong");

  a_upper_b_layout: assert property (
    BUS_RD && BUS_ADDR == IOC_OFF_B_UPPER_CHANGE
      |=> BUS_RDATA[6] == $past(flag_b[6]) && BUS_RDATA[4] == $past(flag_b[4])
      && BUS_RDATA[2] == $past(lvl_ab[14]) && BUS_RDATA[0] == $past(lvl_ab[12])
      && BUS_RDATA[7] == 1'b0 && BUS_RDATA[5] == 1'b0
  ) else $error("port b upper change register layout wrong");

  a_enable_b_reserved: assert property (
    (state.en_b & ~IOC_B_PIN_MASK) == 8'h00
  ) else $error("reserved port b enable bit set");

  a_rts_on_pin: assert property (
    RTS_FLOW_EN |=> PORT_B_DRV.enable[0] && PORT_B_DRV.level[0] == $past(REQUEST_TO_SEND_N)
  ) else $error("request-to-send not on pin 0b");

  a_field_off: assert property (
    BUS_WR && BUS_ADDR == IOC_OFF_PORT_CONFIG_0 && BUS_WDATA[1:0] == 2'b00
      |=> ##1 !PORT_A_DRV.enable[0]
  ) else $error("field 00 left driver on");
endmodule // ioc_top
`default_nettype wire

// *** verification/ioc_pins_model.sv ***
// pin model: outside drivers and the block's own drivers meet on each pin
`timescale 1ns/1ps
`default_nettype none
module ioc_pins_model
  import ioc_pkg::*;
(
  input wire ioc_drive_s drv_a, // block drive, port a
  input wire ioc_drive_s drv_b, // block drive, port b
  input wire logic [7:0] ext_a, // outside level, port a
  input wire logic [7:0] ext_b, // outside level, port b
  output logic [7:0] pin_a, // resolved port a pins
  output logic [7:0] pin_b // resolved port b pins
);
  // driven level seen
  // outside side yields wherever the block drives, so no contention
  assign pin_a = (drv_a.enable & drv_a.level) | (~drv_a.enable & ext_a);
  assign pin_b = (drv_b.enable & drv_b.level) | (~drv_b.enable & ext_b);
endmodule // ioc_pins_model
`default_nettype wire

// *** verification/ioc_top_tb.sv ***
// self-checking bench of the i/o port input-change block
`timescale 1ns/1ps
`default_nettype none
module ioc_top_tb
  import ioc_pkg::*;
;
  logic sys_clk, rst_n, bus_wr, bus_rd, rts_en, rts_n, eot_en, eot_lvl, pending;
  logic [7:0] addr, wdata, rdata, ext_a, ext_b, pin_a, pin_b, src_a, src_b, lvl_a, lvl_b;
  ioc_drive_s drv_a, drv_b;
  int errors, n_compared;

  ioc_top dut (.SYS_CLK(sys_clk), .RESET_N(rst_n), .BUS_ADDR(addr), .BUS_WDATA(wdata),
    .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_RDATA(rdata), .PORT_A_IN(pin_a),
    .PORT_B_IN(pin_b), .PORT_A_SRC(src_a), .PORT_B_SRC(src_b), .PORT_A_DRV(drv_a),
    .PORT_B_DRV(drv_b), .RTS_FLOW_EN(rts_en), .REQUEST_TO_SEND_N(rts_n),
    .EOT_EN(eot_en), .EOT_LEVEL(eot_lvl), .LEVEL_A(lvl_a), .LEVEL_B(lvl_b),
    .CHANGE_PENDING(pending));

  ioc_pins_model pins (.drv_a(drv_a), .drv_b(drv_b), .ext_a(ext_a), .ext_b(ext_b),
    .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // one-cycle strobe; data lands on the strobe edge and then holds
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(rdata, exp);
  endtask

  // synchroniser plus detector need three edges; six leaves margin
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset();
    chk(rdata, 8'h00);
    chk(drv_a.enable, 8'h00);
    chk(drv_b.enable, 8'h00);
    chk({7'h00, pending}, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_levels();
    @(posedge sys_clk);
    ext_a <= 8'ha5;
    ext_b <= 8'hff;
    settle();
    chk(lvl_a, 8'ha5);
    chk(lvl_b, 8'h5d);
    rd(IOC_OFF_A_LEVEL, 8'ha5);
    rd(IOC_OFF_B_LEVEL, 8'h5d);
    rd(IOC_OFF_B_UPPER_CHANGE, 8'h05);
    rd(8'h40, 8'h00);
    $display("test levels done");
  endtask

  task automatic t_enables();
    wr(IOC_OFF_A_DETECT_ENABLE, 8'hff);
    rd(IOC_OFF_A_DETECT_ENABLE, 8'hff);
    wr(IOC_OFF_B_DETECT_ENABLE, 8'hff);
    rd(IOC_OFF_B_DETECT_ENABLE, 8'h5d);
    $display("test enables done");
  endtask

  task automatic t_change();
    @(posedge sys_clk);
    ext_b <= 8'hbf;
    settle();
    chk({7'h00, pending}, 8'h01);
    rd(IOC_OFF_B_UPPER_CHANGE, 8'h41);
    rd(IOC_OFF_B_UPPER_CHANGE, 8'h01);
    @(posedge sys_clk);
    ext_a <= 8'ha4;
    settle();
    rd(IOC_OFF_A_LOWER_CHANGE, 8'h14);
    $display("test change done");
  endtask

  task automatic t_disabled();
    wr(IOC_OFF_A_DETECT_ENABLE, 8'h00);
    @(posedge sys_clk);
    ext_a <= 8'h5b;
    settle();
    rd(IOC_OFF_A_LOWER_CHANGE, 8'h0b);
    rd(IOC_OFF_A_UPPER_CHANGE, 8'h05);
    $display("test disabled done");
  endtask

  task automatic t_output();
    @(posedge sys_clk);
    src_a <= 8'h01;
    wr(IOC_OFF_A_DETECT_ENABLE, 8'h01);
    wr(IOC_OFF_PORT_CONFIG_0, 8'h01);
    settle();
    chk(drv_a.enable, 8'h01);
    chk(drv_a.level, 8'h01);
    rd(IOC_OFF_A_LOWER_CHANGE, 8'h0b);
    @(posedge sys_clk);
    src_a <= 8'h00;
    settle();
    rd(IOC_OFF_A_LOWER_CHANGE, 8'h1a);
    $display("test output done");
  endtask

  task automatic t_pin0b();
    @(posedge sys_clk);
    rts_en <= 1'b1;
    rts_n <= 1'b0;
    eot_en <= 1'b1;
    eot_lvl <= 1'b1;
    settle();
    chk({6'h00, drv_b.enable[0], drv_b.level[0]}, 8'h02);
    @(posedge sys_clk);
    rts_en <= 1'b0;
    settle();
    chk({6'h00, drv_b.enable[0], drv_b.level[0]}, 8'h03);
    $display("test pin0b done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // whole run is about 115 cycles; far beyond that means a hang
  initial begin
    #100us;
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    {rst_n, bus_wr, bus_rd, rts_en, rts_n, eot_en, eot_lvl} = 7'h10;
    {addr, wdata, ext_a, ext_b, src_a, src_b} = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 t_reset();
    t_levels();
    t_enables();
    t_change();
    t_disabled();
    t_output();
    t_pin0b();
    final_report();
  end
endmodule // ioc_top_tb
`default_nettype wire
